//--- include/ocp_csa_pkg.sv
package ocp_csa_pkg;
  // ==========================================================
  // Register map
  localparam logic [3:0] ADDR_OCP = 4'h5;
  localparam logic [3:0] ADDR_CSA = 4'h6;
  localparam logic [3:0] ADDR_GATE_HS = 4'h3;
  localparam logic [3:0] ADDR_GATE_LS = 4'h4;
  localparam logic [3:0] ADDR_DRV_CTRL = 4'h2;
  localparam logic [10:0] OCP_RESET = 11'h145;
  localparam logic [10:0] CSA_RESET = 11'h283;
  localparam logic [2:0] LOCK_KEY = 3'h6;
  localparam logic [2:0] UNLOCK_KEY = 3'h3;
  // ==========================================================
  // Field positions
  localparam int OCP_RETRY_BIT = 10;
  localparam int OCP_GAP_LSB = 8;
  localparam int RESPONSE_LSB = 6;
  localparam int OCP_SCOPE_BIT = 5;
  localparam int OCP_VDS_LSB = 0;
  localparam int CSA_HALF_BIT = 9;
  localparam int CSA_LSREF_BIT = 8;
  localparam int AMP_GAIN_LSB = 6;
  localparam int CSA_DIS_BIT = 5;
  localparam int CSA_CAL_BIT = 4;
  localparam int CSA_AUTO_BIT = 3;
  localparam int CSA_SEN_LSB = 0;
  localparam int LOCK_LSB = 8;
  localparam int CLR_BIT = 0;
  localparam int PWM_CLEAR_BIT = 10;
  localparam logic [2:0] VDS_OFF = 3'h7;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int RETRY_LONG_US = 4000;
  localparam int RETRY_SHORT_US = 50;
  localparam int RETRY_LONG_CYC = RETRY_LONG_US * CLK_MHZ;
  localparam int RETRY_SHORT_CYC = RETRY_SHORT_US * CLK_MHZ;
  localparam int GAP_BASE_NS = 50;
  localparam int GAP_BASE_CYC = GAP_BASE_NS * CLK_MHZ / 1000;
  typedef enum logic [1:0] {
    MODE_LATCH = 2'h0,
    MODE_RETRY = 2'h1,
    MODE_REPORT = 2'h2,
    MODE_IGNORE = 2'h3
  } overcurrent_response_sel_type;
  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_LATCHED = 3'h2,
    ST_RETRY = 3'h4
  } fault_state_type;
endpackage

//--- verilog/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  // ==========================================================
  // Three stages, change accepted when stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else if (ce) begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule

//--- verilog/retry_timer.sv
`timescale 1ns/1ps
module retry_timer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic start,
  input wire logic [22:0] length,
  output logic done
);
  logic [22:0] count;
  logic running;
  // ==========================================================
  // One-shot counter, done pulses when length cycles elapsed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 23'h0;
      running <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        count <= length;
        running <= 1'b1;
      end else if (running) begin
        if (count <= 23'h1) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 23'h1;
        end
      end
    end
  end
endmodule

//--- verilog/ocp_csa_regs.sv
`timescale 1ns/1ps
// Function
// - Protection register 0x05, eleven bits, reset 0x145
// - Amplifier register 0x06, eleven bits, reset 0x283
// - Bit 10 retry: 4 ms or 50 us
// - Bits 9-8 gap 50 to 400 ns
// - Mode 00 latches, 01 retries
// - Mode 10 reports only, 11 ignores
// - Bit 5 shuts all bridges or only the tripped ones
// - Bits 2-0 trip level, 111 disables monitor
// - Bit 9 halves amplifier reference
// - Bit 8 picks low-side monitor reference
// - Bits 7-6 gain 5 to 40
// - Bit 5 suppresses shunt fault
// - Bit 4 enables amplifier calibration
// - Bit 3 runs automatic offset calibration
// - Bits 1-0 shunt trip level
// - Key 110 locks writes to 0x05 and 0x06, 011 unlocks
// - Cycle clear on PWM in retry mode
// - Clear bit releases latched faults, self-clears
module ocp_csa_regs
  import ocp_csa_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [10:0] wr_data,
  input wire logic [3:0] rd_addr,
  output logic [10:0] rd_data,
  input wire logic cycle_clear_on_pwm,
  input wire logic pwm_in,
  input wire logic [2:0] drain_source_trip_pin,
  input wire logic [2:0] shunt_trip_pin,
  output logic [2:0] bridge_enable,
  output logic fault_report,
  output logic [1:0] shoot_through_gap_sel,
  output logic [6:0] gap_cycles,
  output logic [2:0] drain_source_trip_threshold,
  output logic drain_source_monitor_enable,
  output logic amp_reference_halving,
  output logic lowside_monitor_reference_sel,
  output logic [1:0] shunt_amp_gain_sel,
  output logic amp_calibration_enable,
  output logic amp_offset_autotrim,
  output logic [1:0] shunt_trip_threshold,
  output logic locked
);
  import ocp_csa_pkg::*;
  logic [10:0] overcurrent_protection_control;
  logic [10:0] shunt_amplifier_control;
  logic [2:0] ds_sync;
  logic [2:0] sh_sync;
  logic pwm_sync;
  logic pwm_prev;
  logic pwm_edge;
  logic [2:0] trip;
  logic [2:0] fault_phase;
  logic any_trip;
  logic timer_done;
  logic timer_start;
  logic clear_latched_faults;
  logic wr_ok;
  overcurrent_response_sel_type mode;
  fault_state_type state;
  fault_state_type next_state;

  // ==========================================================
  // Pin synchronisers
  for (genvar i = 0; i < 3; i++) begin : g_sync
    pin_sync ds_i (.clk(clk), .rstn(rstn), .ce(ce),
      .pin(drain_source_trip_pin[i]), .level(ds_sync[i]));
    pin_sync sh_i (.clk(clk), .rstn(rstn), .ce(ce),
      .pin(shunt_trip_pin[i]), .level(sh_sync[i]));
  end
  pin_sync pwm_i (.clk(clk), .rstn(rstn), .ce(ce),
    .pin(pwm_in), .level(pwm_sync));

  // ==========================================================
  // Register writes
  assign wr_ok = wr_en && !locked;
  assign clear_latched_faults = wr_en && wr_addr == ADDR_DRV_CTRL
    && wr_data[CLR_BIT];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      overcurrent_protection_control <= OCP_RESET;
    end else if (ce && wr_ok && wr_addr == ADDR_OCP) begin
      overcurrent_protection_control <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shunt_amplifier_control <= CSA_RESET;
    end else if (ce && wr_ok && wr_addr == ADDR_CSA) begin
      shunt_amplifier_control <= wr_data;
    end
  end

  // Lock key lives in the high-side gate register, always writable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      locked <= 1'b0;
    end else if (ce && wr_en && wr_addr == ADDR_GATE_HS) begin
      if (wr_data[LOCK_LSB +: 3] == LOCK_KEY) begin
        locked <= 1'b1;
      end else if (wr_data[LOCK_LSB +: 3] == UNLOCK_KEY) begin
        locked <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read port
  always_comb begin
    unique case (rd_addr)
      ADDR_OCP: rd_data = overcurrent_protection_control;
      ADDR_CSA: rd_data = shunt_amplifier_control;
      default: rd_data = 11'h000;
    endcase
  end

  // ==========================================================
  // Field decode
  assign mode = overcurrent_response_sel_type'(
    overcurrent_protection_control[RESPONSE_LSB +: 2]);
  assign shoot_through_gap_sel =
    overcurrent_protection_control[OCP_GAP_LSB +: 2];
  assign drain_source_trip_threshold =
    overcurrent_protection_control[OCP_VDS_LSB +: 3];
  assign drain_source_monitor_enable =
    drain_source_trip_threshold != VDS_OFF;
  assign amp_reference_halving =
    shunt_amplifier_control[CSA_HALF_BIT];
  assign lowside_monitor_reference_sel =
    shunt_amplifier_control[CSA_LSREF_BIT];
  assign shunt_amp_gain_sel =
    shunt_amplifier_control[AMP_GAIN_LSB +: 2];
  assign amp_calibration_enable =
    shunt_amplifier_control[CSA_CAL_BIT];
  assign amp_offset_autotrim =
    shunt_amplifier_control[CSA_AUTO_BIT];
  assign shunt_trip_threshold =
    shunt_amplifier_control[CSA_SEN_LSB +: 2];

  // Gap of 50 ns doubled per code step
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_cycles <= 7'h00;
    end else if (ce) begin
      gap_cycles <= 7'(GAP_BASE_CYC << shoot_through_gap_sel);
    end
  end

  // ==========================================================
  // Overcurrent detection
  always_comb begin
    trip = 3'h0;
    if (drain_source_monitor_enable) begin
      trip = trip | ds_sync;
    end
    if (!shunt_amplifier_control[CSA_DIS_BIT]) begin
      trip = trip | sh_sync;
    end
  end
  assign any_trip = |trip;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwm_prev <= 1'b0;
    end else if (ce) begin
      pwm_prev <= pwm_sync;
    end
  end
  assign pwm_edge = pwm_sync && !pwm_prev;

  // ==========================================================
  // Fault state machine
  assign timer_start = state == ST_RUN && next_state == ST_RETRY;

  retry_timer timer_i (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .start(timer_start),
    .length(overcurrent_protection_control[OCP_RETRY_BIT]
      ? 23'(RETRY_SHORT_CYC) : 23'(RETRY_LONG_CYC)),
    .done(timer_done)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (any_trip && mode == MODE_LATCH) begin
          next_state = ST_LATCHED;
        end else if (any_trip && mode == MODE_RETRY) begin
          next_state = ST_RETRY;
        end
      end
      ST_LATCHED: begin
        if (clear_latched_faults) begin
          next_state = ST_RUN;
        end
      end
      ST_RETRY: begin
        if (timer_done) begin
          next_state = ST_RUN;
        end else if (cycle_clear_on_pwm && pwm_edge) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_RUN;
    end else if (ce) begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fault_phase <= 3'h0;
    end else if (ce) begin
      if (state == ST_RUN) begin
        fault_phase <= trip;
      end
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bridge_enable <= 3'h7;
      fault_report <= 1'b0;
    end else if (ce) begin
      if (next_state == ST_RUN) begin
        bridge_enable <= 3'h7;
      end else if (overcurrent_protection_control[OCP_SCOPE_BIT]) begin
        bridge_enable <= ~(state == ST_RUN ? trip : fault_phase);
      end else begin
        bridge_enable <= 3'h0;
      end
      fault_report <= next_state != ST_RUN
        || (any_trip && mode == MODE_REPORT);
    end
  end
endmodule

//--- dv/host_model.sv
`timescale 1ns/1ps
// ==========
// Register host
module host_model (
  input wire logic clk,
  output logic wr_en,
  output logic [3:0] wr_addr,
  output logic [10:0] wr_data,
  output logic [3:0] rd_addr,
  input wire logic [10:0] rd_data
);
  initial begin
    wr_en = 1'b0;
    wr_addr = 4'h0;
    wr_data = 11'h000;
    rd_addr = 4'h0;
  end
  // One-cycle strobe; also carries lock keys and clear
  task automatic wr(input logic [3:0] a, input logic [10:0] d);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [10:0] d);
    rd_addr <= a;
    @(posedge clk);
    @(negedge clk);
    d = rd_data;
    @(posedge clk);
  endtask
endmodule

//--- dv/ocp_csa_monitor.sv
`timescale 1ns/1ps
// ==========
// Checker
module ocp_csa_monitor
  import ocp_csa_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [10:0] wr_data,
  input wire logic [3:0] rd_addr,
  input wire logic [10:0] rd_data,
  input wire logic [1:0] shoot_through_gap_sel,
  input wire logic [6:0] gap_cycles,
  input wire logic [2:0] drain_source_trip_threshold,
  input wire logic drain_source_monitor_enable,
  input wire logic [1:0] shunt_amp_gain_sel,
  input wire logic locked
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_wr(a);
    ce && wr_en && wr_addr == a;
  endsequence
  property p_wr_ocp;
    s_wr(ADDR_OCP) ##0 !locked |=> shoot_through_gap_sel ==
      $past(wr_data[9:8]) && drain_source_trip_threshold ==
      $past(wr_data[2:0]);
  endproperty
  a_wr_ocp: assert property (p_wr_ocp)
    else $error("protection write");
  property p_wr_csa;
    s_wr(ADDR_CSA) ##0 !locked |=> shunt_amp_gain_sel ==
      $past(wr_data[7:6]);
  endproperty
  a_wr_csa: assert property (p_wr_csa)
    else $error("amp write");
  property p_rd_ocp;
    rd_addr == ADDR_OCP |-> rd_data[9:8] == shoot_through_gap_sel &&
      rd_data[2:0] == drain_source_trip_threshold;
  endproperty
  a_rd_ocp: assert property (p_rd_ocp)
    else $error("protection read");
  property p_lock_ign;
    s_wr(ADDR_OCP) ##0 locked |=> $stable(shoot_through_gap_sel) &&
      $stable(drain_source_trip_threshold);
  endproperty
  a_lock_ign: assert property (p_lock_ign)
    else $error("locked write");
  property p_lock;
    s_wr(ADDR_GATE_HS) ##0 wr_data[10:8] == LOCK_KEY |=> locked;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock");
  property p_unlock;
    s_wr(ADDR_GATE_HS) ##0 wr_data[10:8] == UNLOCK_KEY |=> !locked;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlock");
  property p_gap;
    ce && $stable(shoot_through_gap_sel) |=>
      {1'b0, gap_cycles} == 8'h0A << $past(shoot_through_gap_sel);
  endproperty
  a_gap: assert property (p_gap)
    else $error("gap");
  property p_mon;
    $stable(drain_source_trip_threshold) |-> drain_source_monitor_enable
      == (drain_source_trip_threshold != VDS_OFF);
  endproperty
  a_mon: assert property (p_mon)
    else $error("monitor");
endmodule
bind ocp_csa_regs ocp_csa_monitor mon_u (.clk(clk), .rstn(rstn),
  .ce(ce), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
  .rd_addr(rd_addr), .rd_data(rd_data), .locked(locked),
  .shoot_through_gap_sel(shoot_through_gap_sel), .gap_cycles(gap_cycles),
  .drain_source_trip_threshold(drain_source_trip_threshold),
  .drain_source_monitor_enable(drain_source_monitor_enable),
  .shunt_amp_gain_sel(shunt_amp_gain_sel));

//--- dv/overcurrent_and_shunt_amp_config_test.sv
`timescale 1ns/1ps
// ==========
// Bench
module overcurrent_and_shunt_amp_config_test;
  import ocp_csa_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic pwm_clr = 1'b0;
  logic ce = 1'b1;
  logic pwm = 1'b0;
  logic [2:0] ds = 3'h0;
  logic [2:0] sh = 3'h0;
  logic we;
  logic [3:0] wa;
  logic [3:0] ra;
  logic [10:0] wd;
  logic [10:0] rdd;
  logic [10:0] v;
  logic [10:0] e;
  logic [2:0] be;
  logic [2:0] thr;
  logic [1:0] gap;
  logic [1:0] gain;
  logic [1:0] sen;
  logic [6:0] gc;
  logic fr, mon, half, lsr, cal, aut, lk;
  int bad_count = 0;
  int tests_run = 0;
  int n;
  always #2.5 clk = ~clk;
  host_model h (.clk(clk), .wr_en(we), .wr_addr(wa), .wr_data(wd),
    .rd_addr(ra), .rd_data(rdd));
  ocp_csa_regs dut_u (.clk(clk), .rstn(rstn), .ce(ce), .wr_en(we),
    .wr_addr(wa), .wr_data(wd), .rd_addr(ra), .rd_data(rdd),
    .cycle_clear_on_pwm(pwm_clr), .pwm_in(pwm), .drain_source_trip_pin(ds),
    .shunt_trip_pin(sh), .bridge_enable(be), .fault_report(fr),
    .shoot_through_gap_sel(gap), .gap_cycles(gc),
    .drain_source_trip_threshold(thr), .drain_source_monitor_enable(mon),
    .amp_reference_halving(half), .lowside_monitor_reference_sel(lsr),
    .shunt_amp_gain_sel(gain), .amp_calibration_enable(cal),
    .amp_offset_autotrim(aut), .shunt_trip_threshold(sen), .locked(lk));
  task automatic summarize;
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(string s, logic [10:0] x, logic [10:0] y);
    tests_run++;
    if (y !== x) begin
      $display("[ERR] %s exp %h got %h", s, x, y);
      bad_count++;
    end
  endtask
  task automatic wt(logic [2:0] x, int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        chk("wait", x, be);
        summarize();
      end
    end while (be !== x);
    @(posedge clk);
  endtask
  // Program, raise trip pins, check after the pin sync delay
  task automatic hit(logic [10:0] o, c, logic [5:0] p, logic [2:0] x,
    logic f);
    // Let the previous trip pins fall through the synchronisers
    repeat (5) @(posedge clk);
    h.wr(ADDR_OCP, o);
    h.wr(ADDR_CSA, c);
    {ds, sh} <= p;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("bridges", x, be);
    chk("report", f, fr);
    @(posedge clk);
    {ds, sh} <= 6'h0;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    h.rd(ADDR_OCP, v);
    chk("ocp", OCP_RESET, v);
    h.rd(ADDR_CSA, v);
    chk("csa", CSA_RESET, v);
    for (int i = 0; i < 4; i++) begin
      e = {1'b1, i[1:0], i[1:0], 1'b1, 2'h3, 3'h7};
      h.wr(ADDR_OCP, e);
      h.rd(ADDR_OCP, v);
      chk("ocp", e, v);
      chk("gap", 11'h00A << i, {4'h0, gc});
      chk("vds", {i[1:0], 3'h7, 1'b0}, {gap, thr, mon});
      e = {1'b1, i[0], ~i[0], i[1:0], i[1], i[0], ~i[0], 1'b1, i[1:0]};
      h.wr(ADDR_CSA, e);
      h.rd(ADDR_CSA, v);
      chk("csa", e, v);
      chk("ref", {e[9:8], e[1:0]}, {half, lsr, sen});
      chk("gain", {e[7:6], e[4:3]}, {gain, cal, aut});
    end
    // Clock enable low: the write must not be taken
    ce <= 1'b0;
    h.wr(ADDR_OCP, 11'h000);
    ce <= 1'b1;
    h.rd(ADDR_OCP, v);
    chk("frozen", 11'h7FF, v);
    h.wr(ADDR_GATE_HS, 11'h600);
    chk("lock", 11'h001, {10'h0, lk});
    h.wr(ADDR_OCP, 11'h000);
    h.rd(ADDR_OCP, v);
    chk("locked", 11'h7FF, v);
    h.wr(ADDR_GATE_HS, 11'h300);
    chk("unlock", 11'h000, {10'h0, lk});
    hit(11'h000, 11'h000, 6'h08, 3'h0, 1'b1);
    repeat (20) @(posedge clk);
    chk("latched", 11'h000, {8'h0, be});
    h.wr(ADDR_DRV_CTRL, 11'h001);
    wt(3'h7, 8);
    hit(11'h460, 11'h000, 6'h02, 3'h5, 1'b1);
    wt(3'h7, 10100);
    chk("retry", 11'h001, {10'h0, n > 9990 && n < 10006});
    // Long retry still holds the bridge off, then a PWM edge clears it
    hit(11'h060, 11'h000, 6'h02, 3'h5, 1'b1);
    repeat (10100) @(posedge clk);
    chk("long", 11'h005, {8'h0, be});
    pwm_clr <= 1'b1;
    pwm <= 1'b1;
    wt(3'h7, 12);
    pwm <= 1'b0;
    pwm_clr <= 1'b0;
    hit(11'h080, 11'h000, 6'h20, 3'h7, 1'b1);
    hit(11'h0C0, 11'h000, 6'h20, 3'h7, 1'b0);
    hit(11'h000, 11'h020, 6'h04, 3'h7, 1'b0);
    hit(11'h007, 11'h000, 6'h20, 3'h7, 1'b0);
    // Second reset while locked and reprogrammed
    h.wr(ADDR_GATE_HS, 11'h600);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    h.rd(ADDR_OCP, v);
    chk("ocp", OCP_RESET, v);
    h.rd(ADDR_CSA, v);
    chk("csa", CSA_RESET, v);
    chk("unlock", 11'h000, {10'h0, lk});
    summarize();
  end
endmodule
